// *** dv/aotc_spi_host.sv ***
`timescale 1ns/1ps
module aotc_spi_host (
   input wire logic clk_sys,
   output logic spi_sclk,
   output logic spi_csb,
   output logic spi_sdio_i,
   input wire logic spi_sdio_o,
   input wire logic spi_sdio_oe
);
   logic hbit;
   logic hen;
   // A released line shows the inverse of the host's bit, so stale data never reads right.
   assign spi_sdio_i = spi_sdio_oe ? spi_sdio_o : (hen ? hbit : ~hbit);
   initial begin
      spi_sclk = 1'b0;
      spi_csb = 1'b1;
      hbit = 1'b0;
      hen = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Every serial level is held three clocks, one more than the port needs.
   task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] wd,
                       output logic [7:0] q);
      logic [23:0] fr;
      fr = {rd, 2'b00, a, wd};
      q = 8'h00;
      spi_csb = 1'b0;
      tick(3);
      for (int i = 23; i >= 0; i--) begin
         hen = !(rd && i < 8);
         hbit = fr[i];
         tick(3);
         if (!hen) q[i] = spi_sdio_i;
         spi_sclk = 1'b1;
         tick(3);
         spi_sclk = 1'b0;
      end
      tick(3);
      spi_csb = 1'b1;
      hen = 1'b1;
      tick(3);
   endtask
endmodule

// *** dv/aotc_top_bench.sv ***
`timescale 1ns/1ps
module aotc_top_bench;
   localparam int DW = 14;
   localparam int NCH = 2;
   localparam logic [12:0] RA [7] = '{13'h000D, 13'h000E, 13'h0010, 13'h0014, 13'h0015,
                                      13'h0016, 13'h0017};
   localparam logic [7:0] RV [7] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h00, 8'h00};
   localparam logic [7:0] RW [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hF7, 8'hFF, 8'hFF};
   localparam logic [7:0] RM [7] = '{8'hBF, 8'h05, 8'h3F, 8'h17, 8'h07, 8'h80, 8'h9F};
   localparam logic [7:0] DL [4] = '{8'h9F, 8'h8A, 8'h80, 8'h1F};
   localparam logic [7:0] OM [5] = '{8'h04, 8'h05, 8'h06, 8'h01, 8'h14};
   localparam logic [7:0] TC [7] = '{8'h01, 8'h02, 8'h25, 8'h35, 8'h16, 8'h36, 8'h00};
   localparam logic [13:0] TE [7] = '{14'h2000, 14'h3FFF, 14'h3FFF, 14'h3FFF, 14'h01FF,
                                      14'h01FF, 14'h1234};
   localparam logic [13:0] UP [5] = '{14'h1111, 14'h2222, 14'h0333, 14'h0000, 14'h0000};
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic spi_sclk;
   logic spi_csb;
   logic spi_sdio_i;
   logic spi_sdio_o;
   logic spi_sdio_oe;
   logic samp_valid = 1'b0;
   logic [NCH-1:0][DW-1:0] samp_data = '0;
   aotc_pkg::aotc_upat_s user_pat = '{16'h1111, 16'h2222, 16'h0333};
   logic [NCH-1:0][DW-1:0] dout;
   logic [NCH-1:0] dout_oe;
   logic dout_valid;
   logic [3:0] lvds_drive;
   logic dco_invert;
   logic [11:0] dco_delay_ps;
   logic [NCH-1:0][15:0] builtin_selftest_sig;
   logic [7:0] q;
   logic [15:0] e;
   int n_errors = 0;
   int num_checks = 0;
   int n_samp = 0;
   always #20 clk_sys = ~clk_sys;
   aotc_top #(.DW(DW), .NCH(NCH)) i_aotc_top (
      .clk_sys(clk_sys), .resetn(resetn), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
      .spi_sdio_i(spi_sdio_i), .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe),
      .samp_valid(samp_valid), .samp_data(samp_data), .user_pat(user_pat), .dout(dout),
      .dout_oe(dout_oe), .dout_valid(dout_valid), .lvds_drive(lvds_drive),
      .dco_invert(dco_invert), .dco_delay_ps(dco_delay_ps), .builtin_selftest_sig(builtin_selftest_sig));
   aotc_spi_host i_aotc_spi_host (
      .clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_csb(spi_csb), .spi_sdio_i(spi_sdio_i),
      .spi_sdio_o(spi_sdio_o), .spi_sdio_oe(spi_sdio_oe));
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
      cmp16({8'h00, got}, {8'h00, exp});
   endtask
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      logic [7:0] x;
      i_aotc_spi_host.xfer(1'b0, a, d, x);
   endtask
   task automatic rd_chk(input logic [12:0] a, input logic [7:0] ex);
      i_aotc_spi_host.xfer(1'b1, a, 8'h00, q);
      cmp8(q, ex);
   endtask
   task automatic cfg(input logic [12:0] a, input logic [7:0] d);
      wr(a, d);
      wr(13'h00FF, 8'h01);
      i_aotc_spi_host.tick(3);
   endtask
   task automatic sample(input logic [DW-1:0] a, input logic [DW-1:0] b);
      samp_valid = 1'b1;
      samp_data = {b, a};
      n_samp++;
      i_aotc_spi_host.tick(1);
      samp_valid = 1'b0;
      cmp16(16'(dout_valid), 16'h0001);
      i_aotc_spi_host.tick(1);
   endtask
   task automatic chk_out(input logic [DW-1:0] e0, input logic [DW-1:0] e1);
      cmp16(16'(dout[0]), 16'(e0));
      cmp16(16'(dout[1]), 16'(e1));
   endtask
   // Expected word for an offset-binary value under a given output mode byte.
   function automatic logic [DW-1:0] fmt(input logic [DW-1:0] b, input logic [7:0] m);
      logic [DW-1:0] f;
      f = (m[1:0] == 2'b01) ? b ^ 14'h2000 : (m[1:0] == 2'b10) ? b ^ (b >> 1) : b;
      if (!m[2]) f = ~f;
      return m[4] ? '0 : f;
   endfunction
   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #2ms;
      n_errors++;
      print_verdict();
   end
   initial begin
      repeat (6) @(posedge clk_sys);
      #1 resetn = 1'b1;
      i_aotc_spi_host.tick(2);
      cmp16(16'(lvds_drive), 16'h0001);
      cmp16({dco_invert, 3'h0, dco_delay_ps}, 16'h0000);
      cmp16(16'(dout_oe), 16'h0003);
      cmp16(builtin_selftest_sig[0], 16'hFFFF);
      for (int i = 0; i < 7; i++) rd_chk(RA[i], RV[i]);
      // Open bits are written as ones; drive keeps a legal code in its low nibble.
      for (int i = 0; i < 7; i++) begin
         wr(RA[i], RW[i]);
         rd_chk(RA[i], RM[i]);
      end
      wr(13'h0011, 8'hFF);
      rd_chk(13'h0011, 8'h00);
      for (int i = 0; i < 7; i++) wr(RA[i], RV[i]);
      cfg(13'h0015, 8'h01);
      wr(13'h0015, 8'h03);
      i_aotc_spi_host.tick(3);
      cmp16(16'(lvds_drive), 16'h0001);
      for (int c = 0; c < 8; c++) begin
         cfg(13'h0015, 8'(c));
         cmp16(16'(lvds_drive), 16'(c));
      end
      cfg(13'h0016, 8'h80);
      cmp16(16'(dco_invert), 16'h0001);
      for (int i = 0; i < 4; i++) begin
         cfg(13'h0017, DL[i]);
         e = DL[i][7] ? 16'((3100 * DL[i][4:0]) / 31 + 100) : 16'h0000;
         cmp16(16'(dco_delay_ps), e);
      end
      for (int i = 0; i < 5; i++) begin
         cfg(13'h0014, OM[i]);
         sample(14'h1234, 14'h2ABC);
         chk_out(fmt(14'h1234, OM[i]), fmt(14'h2ABC, OM[i]));
         cmp16(16'(dout_oe), OM[i][4] ? 16'h0000 : 16'h0003);
      end
      cfg(13'h0014, 8'h04);
      for (int i = 0; i < 7; i++) begin
         cfg(13'h000D, TC[i]);
         sample(14'h1234, 14'h1234);
         chk_out(TE[i], TE[i]);
      end
      // The alternating and toggle patterns flip on every valid since reset.
      cfg(13'h000D, 8'h03);
      sample(14'h1234, 14'h1234);
      chk_out(14'h0000, 14'h0000);
      cfg(13'h000D, 8'h04);
      e = n_samp[0] ? 16'h2AAA : 16'h1555;
      sample(14'h1234, 14'h1234);
      chk_out(e[13:0], e[13:0]);
      cfg(13'h000D, 8'h07);
      e = n_samp[0] ? 16'h3FFF : 16'h0000;
      sample(14'h1234, 14'h1234);
      chk_out(e[13:0], e[13:0]);
      wr(13'h000D, 8'h02);
      cfg(13'h0014, 8'h05);
      sample(14'h1234, 14'h1234);
      chk_out(14'h1FFF, 14'h1FFF);
      cfg(13'h0014, 8'h00);
      sample(14'h1234, 14'h1234);
      chk_out(14'h0000, 14'h0000);
      cfg(13'h0014, 8'h04);
      cfg(13'h000D, 8'h05);
      sample(14'h1234, 14'h1234);
      sample(14'h1234, 14'h1234);
      cmp16(16'(dout[0] == 14'h3FFF), 16'h0000);
      cfg(13'h000D, 8'h88);
      for (int k = 0; k < 5; k++) begin
         sample(14'h1234, 14'h1234);
         chk_out(UP[k], UP[k]);
      end
      cfg(13'h000D, 8'h00);
      wr(13'h0005, 8'h01);
      cfg(13'h0010, 8'h3F);
      sample(14'h2000, 14'h2ABC);
      chk_out(14'h1FFF, 14'h2ABC);
      wr(13'h0005, 8'h02);
      cfg(13'h0010, 8'h1F);
      cfg(13'h0015, 8'h05);
      cmp16(16'(lvds_drive), 16'h0005);
      sample(14'h3FF0, 14'h3FF0);
      chk_out(14'h3FEF, 14'h3FFF);
      wr(13'h0005, 8'h03);
      cfg(13'h000E, 8'h05);
      sample(14'h1234, 14'h2ABC);
      sample(14'h0F0F, 14'h3C3C);
      cmp16(builtin_selftest_sig[0], 16'hFFFF);
      cmp16(builtin_selftest_sig[1], 16'hFFFF);
      cfg(13'h000E, 8'h01);
      sample(14'h1234, 14'h2ABC);
      cmp16(16'(builtin_selftest_sig[0] == 16'hFFFF), 16'h0000);
      print_verdict();
   end
endmodule

// *** hw/aotc_pkg.sv ***
package aotc_pkg;
   typedef enum logic [3:0] {
      AOTC_TP_OFF = 4'b0000,
      AOTC_TP_MID = 4'b0001,
      AOTC_TP_PFS = 4'b0010,
      AOTC_TP_NFS = 4'b0011,
      AOTC_TP_ALT = 4'b0100,
      AOTC_TP_PNL = 4'b0101,
      AOTC_TP_PNS = 4'b0110,
      AOTC_TP_TOG = 4'b0111,
      AOTC_TP_USER = 4'b1000
   } aotc_tp_e;
   typedef enum logic [2:0] {
      AOTC_SPI_IDLE = 3'b000,
      AOTC_SPI_INSTR = 3'b001,
      AOTC_SPI_WDATA = 3'b010,
      AOTC_SPI_RLOAD = 3'b011,
      AOTC_SPI_RDATA = 3'b100,
      AOTC_SPI_DONE = 3'b101
   } aotc_spi_e;
   typedef struct packed {
      logic [7:0] test;
      logic [7:0] builtin_selftest;
      logic [7:0] ofs;
      logic [7:0] outm;
   } aotc_chcfg_s;
   typedef struct packed {
      logic [7:0] drive;
      logic [7:0] phase;
      logic [7:0] delay;
   } aotc_glcfg_s;
   typedef struct packed {
      logic [15:0] p1;
      logic [15:0] p2;
      logic [15:0] p3;
   } aotc_upat_s;
endpackage

// *** hw/aotc_regs.svh ***
`ifndef AOTC_REGS_SVH
`define AOTC_REGS_SVH
`define AOTC_ADDR_CHIDX 13'h0005
`define AOTC_ADDR_TEST 13'h000D
`define AOTC_ADDR_BUILTIN_SELFTEST 13'h000E
`define AOTC_ADDR_OFS 13'h0010
`define AOTC_ADDR_OUTM 13'h0014
`define AOTC_ADDR_DRIVE 13'h0015
`define AOTC_ADDR_PHASE 13'h0016
`define AOTC_ADDR_DELAY 13'h0017
`define AOTC_ADDR_XFER 13'h00FF
`define AOTC_RST_CHIDX 8'h03
`define AOTC_RST_TEST 8'h00
`define AOTC_RST_BUILTIN_SELFTEST 8'h00
`define AOTC_RST_OFS 8'h00
`define AOTC_RST_OUTM 8'h05
`define AOTC_RST_DRIVE 8'h01
`define AOTC_RST_PHASE 8'h00
`define AOTC_RST_DELAY 8'h00
`define AOTC_MSK_CHIDX 8'h03
`define AOTC_MSK_TEST 8'hBF
`define AOTC_MSK_BUILTIN_SELFTEST 8'h05
`define AOTC_MSK_OFS 8'h3F
`define AOTC_MSK_OUTM 8'h17
`define AOTC_MSK_DRIVE 8'h0F
`define AOTC_MSK_PHASE 8'h80
`define AOTC_MSK_DELAY 8'h9F
`define AOTC_TM_SINGLE 7
`define AOTC_TM_RST_LONG 5
`define AOTC_TM_RST_SHORT 4
`define AOTC_BUILTIN_SELFTEST_EN 0
`define AOTC_BUILTIN_SELFTEST_RST 2
`define AOTC_OM_OEB 4
`define AOTC_OM_POL 2
`define AOTC_PH_INV 7
`define AOTC_DL_EN 7
`define AOTC_XFER_BIT 0
`define AOTC_DLY_SPAN_PS 3100
`define AOTC_DLY_BASE_PS 100
`define AOTC_DLY_STEPS 31
`define AOTC_PNL_SEED 23'h7FFFFF
`define AOTC_PNS_SEED 9'h1FF
`define AOTC_MISR_SEED 16'hFFFF
`define AOTC_SPI_INSTR_LAST 5'h0F
`define AOTC_SPI_DATA_LAST 5'h07
`endif

// *** hw/aotc_spi.sv ***
`timescale 1ns/1ps
`include "aotc_regs.svh"
module aotc_spi (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic sclk,
   input wire logic csb,
   input wire logic sdio_i,
   output logic sdio_o,
   output logic sdio_oe,
   output logic wr_stb,
   output logic [12:0] addr,
   output logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   aotc_pkg::aotc_spi_e st_r;
   logic sclk_q;
   logic [4:0] cnt_r;
   logic [15:0] sh_r;
   logic [7:0] obuf_r;
   wire rise = sclk & ~sclk_q;
   wire fall = ~sclk & sclk_q;
   wire [15:0] sh_in = {sh_r[14:0], sdio_i};
   wire [4:0] cnt_inc = cnt_r + 5'h01;

   // The serial clock is sampled by clk_sys, so it must stay well below a quarter of 25 MHz.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_r <= aotc_pkg::AOTC_SPI_IDLE;
         sclk_q <= 1'b0;
         cnt_r <= 5'h00;
         sh_r <= 16'h0000;
         obuf_r <= 8'h00;
         sdio_o <= 1'b0;
         sdio_oe <= 1'b0;
         wr_stb <= 1'b0;
         addr <= 13'h0000;
         wdata <= 8'h00;
      end else begin
         sclk_q <= sclk;
         wr_stb <= 1'b0;
         if (csb) begin
            st_r <= aotc_pkg::AOTC_SPI_IDLE;
            cnt_r <= 5'h00;
            sdio_oe <= 1'b0;
         end else begin
            case (st_r)
               aotc_pkg::AOTC_SPI_IDLE: st_r <= aotc_pkg::AOTC_SPI_INSTR;
               aotc_pkg::AOTC_SPI_INSTR: if (rise) begin
                  sh_r <= sh_in;
                  cnt_r <= cnt_inc;
                  if (cnt_r == `AOTC_SPI_INSTR_LAST) begin
                     addr <= sh_in[12:0];
                     cnt_r <= 5'h00;
                     st_r <= sh_in[15] ? aotc_pkg::AOTC_SPI_RLOAD : aotc_pkg::AOTC_SPI_WDATA;
                  end
               end
               aotc_pkg::AOTC_SPI_WDATA: if (rise) begin
                  sh_r <= sh_in;
                  cnt_r <= cnt_inc;
                  if (cnt_r == `AOTC_SPI_DATA_LAST) begin
                     wdata <= sh_in[7:0];
                     wr_stb <= 1'b1;
                     st_r <= aotc_pkg::AOTC_SPI_DONE;
                  end
               end
               aotc_pkg::AOTC_SPI_RLOAD: begin
                  obuf_r <= rdata;
                  st_r <= aotc_pkg::AOTC_SPI_RDATA;
               end
               aotc_pkg::AOTC_SPI_RDATA: if (fall) begin
                  sdio_o <= obuf_r[7];
                  obuf_r <= {obuf_r[6:0], 1'b0};
                  sdio_oe <= 1'b1;
                  cnt_r <= cnt_inc;
                  if (cnt_r == `AOTC_SPI_DATA_LAST) begin
                     st_r <= aotc_pkg::AOTC_SPI_DONE;
                  end
               end
               aotc_pkg::AOTC_SPI_DONE: st_r <= aotc_pkg::AOTC_SPI_DONE;
               default: st_r <= aotc_pkg::AOTC_SPI_IDLE;
            endcase
         end
      end
   end
endmodule

// *** hw/aotc_top.sv ***
`timescale 1ns/1ps
`include "aotc_regs.svh"
// How it works
// - Nonzero pattern select replaces samples with test data.
// - Pattern codes: off, midscale, fullscale, alternating, PN, toggle, user.
// - User mode top bit: repeat, or once then zeros.
// - Reset bits hold long and short generators.
// - Self-test runs when enabled, restarts on reset bit.
// - Signed offset trim added to each sample.
// - Format field: offset binary, twos complement, Gray.
// - Polarity bit zero inverts output data bits.
// - Bit four disables the channel outputs.
// - Drive code sets LVDS current, reset code one.
// - Top phase bit inverts data clock output.
// - Delay applied only while enable bit set.
// - Delay equals 3100ps times code over 31 plus 100ps.
// - Local writes reach only selected channels.
// - Writes staged except channel index; transfer bit makes them active.
module aotc_top #(
   parameter int DW = 14,
   parameter int NCH = 2
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic spi_sclk,
   input wire logic spi_csb,
   input wire logic spi_sdio_i,
   output logic spi_sdio_o,
   output logic spi_sdio_oe,
   input wire logic samp_valid,
   input wire logic [NCH-1:0][DW-1:0] samp_data,
   input wire aotc_pkg::aotc_upat_s user_pat,
   output logic [NCH-1:0][DW-1:0] dout,
   output logic [NCH-1:0] dout_oe,
   output logic dout_valid,
   output logic [3:0] lvds_drive,
   output logic dco_invert,
   output logic [11:0] dco_delay_ps,
   output logic [NCH-1:0][15:0] builtin_selftest_sig
);
   if (NCH != 2 || DW < 8 || DW > 16 || (DW % 2) != 0) begin : g_bad
      $error("aotc_top: NCH must be 2 and DW even in 8..16");
   end

   default clocking cbt @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   function automatic logic [DW-1:0] sat_add(input logic [DW-1:0] s, input logic [5:0] o);
      logic signed [DW+1:0] sum;
      sum = $signed({2'b00, s}) + $signed({{(DW-4){o[5]}}, o});
      if (sum[DW+1]) begin
         return '0;
      end else if (sum[DW]) begin
         return '1;
      end
      return sum[DW-1:0];
   endfunction

   function automatic logic [DW-1:0] fmt_word(input logic [DW-1:0] b, input logic [7:0] m);
      logic [DW-1:0] w;
      case (m[1:0])
         2'b01: w = {~b[DW-1], b[DW-2:0]};
         2'b10: w = b ^ (b >> 1);
         default: w = b;
      endcase
      return m[`AOTC_OM_POL] ? w : ~w;
   endfunction

   function automatic logic [DW-1:0] test_word(input aotc_pkg::aotc_tp_e m, input logic [22:0] pl,
                                                input logic [8:0] ps, input logic t,
                                                input logic [DW-1:0] u);
      case (m)
         aotc_pkg::AOTC_TP_MID: test_word = {1'b1, {(DW-1){1'b0}}};
         aotc_pkg::AOTC_TP_PFS: test_word = '1;
         aotc_pkg::AOTC_TP_NFS: test_word = '0;
         aotc_pkg::AOTC_TP_ALT: test_word = t ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
         aotc_pkg::AOTC_TP_PNL: test_word = pl[DW-1:0];
         aotc_pkg::AOTC_TP_PNS: test_word = DW'(ps);
         aotc_pkg::AOTC_TP_TOG: test_word = {DW{t}};
         aotc_pkg::AOTC_TP_USER: test_word = u;
         default: test_word = '0;
      endcase
   endfunction

   function automatic logic [11:0] dly_ps(input logic [4:0] code);
      return 12'((`AOTC_DLY_SPAN_PS * int'(code)) / `AOTC_DLY_STEPS + `AOTC_DLY_BASE_PS);
   endfunction

   logic wr_stb;
   logic [12:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic [7:0] chidx_r;
   aotc_pkg::aotc_chcfg_s ch_sh_r [NCH];
   aotc_pkg::aotc_chcfg_s ch_act_r [NCH];
   aotc_pkg::aotc_glcfg_s gl_sh_r;
   aotc_pkg::aotc_glcfg_s gl_act_r;

   aotc_spi u_spi (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .sclk(spi_sclk),
      .csb(spi_csb),
      .sdio_i(spi_sdio_i),
      .sdio_o(spi_sdio_o),
      .sdio_oe(spi_sdio_oe),
      .wr_stb(wr_stb),
      .addr(addr),
      .wdata(wdata),
      .rdata(rdata)
   );

   wire xfer = wr_stb && addr == `AOTC_ADDR_XFER && wdata[`AOTC_XFER_BIT];
   wire aotc_pkg::aotc_chcfg_s rd_sel = chidx_r[0] ? ch_sh_r[0] : ch_sh_r[NCH-1];
   // Reads show the staged copy; the transfer register always reads zero.
   assign rdata = (addr == `AOTC_ADDR_CHIDX) ? chidx_r :
                  (addr == `AOTC_ADDR_TEST) ? rd_sel.test :
                  (addr == `AOTC_ADDR_BUILTIN_SELFTEST) ? rd_sel.builtin_selftest :
                  (addr == `AOTC_ADDR_OFS) ? rd_sel.ofs :
                  (addr == `AOTC_ADDR_OUTM) ? rd_sel.outm :
                  (addr == `AOTC_ADDR_DRIVE) ? gl_sh_r.drive :
                  (addr == `AOTC_ADDR_PHASE) ? gl_sh_r.phase :
                  (addr == `AOTC_ADDR_DELAY) ? gl_sh_r.delay : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         chidx_r <= `AOTC_RST_CHIDX;
         gl_sh_r <= {`AOTC_RST_DRIVE, `AOTC_RST_PHASE, `AOTC_RST_DELAY};
         gl_act_r <= {`AOTC_RST_DRIVE, `AOTC_RST_PHASE, `AOTC_RST_DELAY};
         for (int i = 0; i < NCH; i++) begin
            ch_sh_r[i] <= {`AOTC_RST_TEST, `AOTC_RST_BUILTIN_SELFTEST, `AOTC_RST_OFS, `AOTC_RST_OUTM};
            ch_act_r[i] <= {`AOTC_RST_TEST, `AOTC_RST_BUILTIN_SELFTEST, `AOTC_RST_OFS, `AOTC_RST_OUTM};
         end
      end else begin
         if (wr_stb) begin
            case (addr) // Open bits are masked off on every write.
               `AOTC_ADDR_CHIDX: chidx_r <= wdata & `AOTC_MSK_CHIDX;
               `AOTC_ADDR_DRIVE: gl_sh_r.drive <= wdata & `AOTC_MSK_DRIVE;
               `AOTC_ADDR_PHASE: gl_sh_r.phase <= wdata & `AOTC_MSK_PHASE;
               `AOTC_ADDR_DELAY: gl_sh_r.delay <= wdata & `AOTC_MSK_DELAY;
               default: chidx_r <= chidx_r;
            endcase
         end
         for (int i = 0; i < NCH; i++) begin
            if (wr_stb && chidx_r[i]) begin
               case (addr)
                  `AOTC_ADDR_TEST: ch_sh_r[i].test <= wdata & `AOTC_MSK_TEST;
                  `AOTC_ADDR_BUILTIN_SELFTEST: ch_sh_r[i].builtin_selftest <= wdata & `AOTC_MSK_BUILTIN_SELFTEST;
                  `AOTC_ADDR_OFS: ch_sh_r[i].ofs <= wdata & `AOTC_MSK_OFS;
                  `AOTC_ADDR_OUTM: ch_sh_r[i].outm <= wdata & `AOTC_MSK_OUTM;
                  default: ch_sh_r[i] <= ch_sh_r[i];
               endcase
            end
            if (xfer) begin
               ch_act_r[i] <= ch_sh_r[i];
            end
         end
         if (xfer) begin
            gl_act_r <= gl_sh_r;
         end
      end
   end

   // Reserved drive codes are passed through unchanged; the host keeps clear of them.
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         lvds_drive <= 4'h1;
         dco_invert <= 1'b0;
         dco_delay_ps <= 12'h000;
         dout_valid <= 1'b0;
      end else begin
         lvds_drive <= gl_act_r.drive[3:0];
         dco_invert <= gl_act_r.phase[`AOTC_PH_INV];
         dco_delay_ps <= gl_act_r.delay[`AOTC_DL_EN] ?
                         dly_ps(gl_act_r.delay[4:0]) : 12'h000;
         dout_valid <= samp_valid;
      end
   end

   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      logic [22:0] pnl_r;
      logic [8:0] pns_r;
      logic tgl_r;
      logic [1:0] uidx_r;
      logic udone_r;
      logic [15:0] sig_r;
      wire aotc_pkg::aotc_chcfg_s cfg = ch_act_r[ch];
      wire aotc_pkg::aotc_tp_e mode = aotc_pkg::aotc_tp_e'(cfg.test[3:0]);
      wire [15:0] upsel = (uidx_r == 2'h0) ? user_pat.p1 :
                          (uidx_r == 2'h1) ? user_pat.p2 : user_pat.p3;
      wire [DW-1:0] upw = udone_r ? '0 : upsel[DW-1:0];
      wire [DW-1:0] tword = test_word(mode, pnl_r, pns_r, tgl_r, upw);
      wire [DW-1:0] base = sat_add(samp_data[ch], cfg.ofs[5:0]);
      wire [DW-1:0] sel = (mode != aotc_pkg::AOTC_TP_OFF) ? tword : base;
      wire [DW-1:0] word = fmt_word(sel, cfg.outm);
      wire oeb = cfg.outm[`AOTC_OM_OEB];
      wire user_m = mode == aotc_pkg::AOTC_TP_USER;

      always_ff @(posedge clk_sys) begin
         if (!resetn) begin
            pnl_r <= `AOTC_PNL_SEED;
            pns_r <= `AOTC_PNS_SEED;
            tgl_r <= 1'b0;
            uidx_r <= 2'h0;
            udone_r <= 1'b0;
            sig_r <= `AOTC_MISR_SEED;
            dout[ch] <= '0;
            dout_oe[ch] <= 1'b0;
         end else begin
            if (cfg.test[`AOTC_TM_RST_LONG]) begin
               pnl_r <= `AOTC_PNL_SEED;
            end else if (samp_valid) begin
               pnl_r <= {pnl_r[21:0], pnl_r[22] ^ pnl_r[17]};
            end
            if (cfg.test[`AOTC_TM_RST_SHORT]) begin
               pns_r <= `AOTC_PNS_SEED;
            end else if (samp_valid) begin
               pns_r <= {pns_r[7:0], pns_r[8] ^ pns_r[4]};
            end
            if (samp_valid) begin
               tgl_r <= ~tgl_r;
            end
            if (!user_m) begin
               uidx_r <= 2'h0;
               udone_r <= 1'b0;
            end else if (samp_valid) begin
               uidx_r <= (uidx_r == 2'h2) ? 2'h0 : uidx_r + 2'h1;
               if (uidx_r == 2'h2 && cfg.test[`AOTC_TM_SINGLE]) begin
                  udone_r <= 1'b1;
               end
            end
            // The signature folds in the formatted word, so it checks the path up to the output-disable gate, not dout itself.
            if (cfg.builtin_selftest[`AOTC_BUILTIN_SELFTEST_RST]) begin
               sig_r <= `AOTC_MISR_SEED;
            end else if (cfg.builtin_selftest[`AOTC_BUILTIN_SELFTEST_EN] && samp_valid) begin
               sig_r <= {sig_r[14:0], sig_r[15] ^ sig_r[4] ^ sig_r[2] ^ sig_r[1]} ^ 16'(word);
            end
            if (samp_valid) begin
               dout[ch] <= oeb ? '0 : word;
            end
            dout_oe[ch] <= ~oeb;
         end
      end
      assign builtin_selftest_sig[ch] = sig_r;

      wire plain = cfg.outm[4:0] == 5'h04;

      chk_test_override: assert property (
         samp_valid && plain && mode == aotc_pkg::AOTC_TP_PFS |=> dout[ch] == '1)
         else $error("full-scale pattern not driven");
      chk_midscale_code: assert property (
         samp_valid && plain && mode == aotc_pkg::AOTC_TP_MID |=>
            dout[ch] == {1'b1, {(DW-1){1'b0}}})
         else $error("midscale pattern wrong");
      chk_user_single: assert property (
         samp_valid && plain && user_m && udone_r |=> dout[ch] == '0)
         else $error("single user pattern did not end in zeros");
      chk_pn_hold: assert property (
         cfg.test[`AOTC_TM_RST_LONG] && cfg.test[`AOTC_TM_RST_SHORT] |=>
            pnl_r == `AOTC_PNL_SEED && pns_r == `AOTC_PNS_SEED)
         else $error("pseudo-random generator not held");
      chk_builtin_selftest_restart: assert property (
         cfg.builtin_selftest[`AOTC_BUILTIN_SELFTEST_RST] |=> sig_r == `AOTC_MISR_SEED)
         else $error("self-test signature not restarted");
      chk_offset_add: assert property (
         samp_valid && plain && mode == aotc_pkg::AOTC_TP_OFF &&
            samp_data[ch] == {1'b1, {(DW-1){1'b0}}} |=>
            dout[ch] == $past(samp_data[ch]) +
               {{(DW-6){$past(cfg.ofs[5])}}, $past(cfg.ofs[5:0])})
         else $error("offset trim not applied");
      chk_twos_msb: assert property (
         samp_valid && cfg.outm[4:0] == 5'h05 && mode == aotc_pkg::AOTC_TP_PFS |=>
            dout[ch] == {1'b0, {(DW-1){1'b1}}})
         else $error("twos complement format wrong");
      chk_invert_data: assert property (
         samp_valid && cfg.outm[4:0] == 5'h00 && mode == aotc_pkg::AOTC_TP_PFS |=> dout[ch] == '0)
         else $error("polarity inversion missing");
      chk_oe_bar: assert property (
         oeb |=> !dout_oe[ch] ##0 dout[ch] == '0 || !$past(samp_valid))
         else $error("disabled channel still enabled");
      cov_user_done: cover property (user_m && udone_r);
      cov_pn_long: cover property (samp_valid && mode == aotc_pkg::AOTC_TP_PNL);
   end

   chk_drive_reset: assert property (disable iff (1'b0)
      !resetn |=> lvds_drive == `AOTC_RST_DRIVE)
      else $error("drive strength reset code wrong");
   chk_dco_invert: assert property (
      gl_act_r.phase[`AOTC_PH_INV] |=> dco_invert)
      else $error("data clock not inverted");
   chk_dco_nodelay: assert property (
      !gl_act_r.delay[`AOTC_DL_EN] |=> dco_delay_ps == 12'h000)
      else $error("delay applied while disabled");
   chk_dco_fullcode: assert property (
      gl_act_r.delay == 8'h9F |=> dco_delay_ps == 12'hC80)
      else $error("full delay code not 3200 ps");
   chk_chan_select: assert property (
      wr_stb && !chidx_r[1] |=> ch_sh_r[1] == $past(ch_sh_r[1]))
      else $error("unselected channel was written");
   chk_shadow_xfer: assert property (
      xfer |=> gl_act_r == $past(gl_sh_r) && ch_act_r[0] == $past(ch_sh_r[0]))
      else $error("transfer did not copy staged values");
   chk_open_bits: assert property (
      addr == `AOTC_ADDR_DRIVE |-> rdata[7:4] == 4'h0)
      else $error("open bits read nonzero");
   cov_transfer: cover property (xfer);
   cov_delay_on: cover property (dco_delay_ps != 12'h000);
endmodule
